//--- rtl/pcil_pkg.sv
`default_nettype none
package pcil_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int GROUPS = 4;
    localparam int GROUP_W = 8;
    localparam int PINS = 32;
    localparam int ADDR_W = 9;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [6:0] IDX_MASK0 = 7'h6B;
    localparam logic [6:0] IDX_MASK1 = 7'h6C;
    localparam logic [6:0] IDX_MASK2 = 7'h6D;
    localparam logic [6:0] IDX_MASK3 = 7'h73;
    localparam logic [6:0] IDX_GROUP_EN = 7'h68;
    localparam logic [6:0] IDX_GROUP_FLAGS = 7'h3B;
    localparam logic [6:0] IDX_CPU_CTRL = 7'h55;
    localparam logic [6:0] IDX_BIT_OP = 7'h30;
    localparam logic [6:0] IDX_PORT_BASE = 7'h20;
    localparam logic [6:0] PORT_STRIDE = 7'h03;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PULLUP_OFF_BIT = 4;
    localparam int BITOP_VAL = 7;
    localparam int BITOP_DIR = 5;
    localparam int BITOP_PORT_LSB = 3;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_GROUP_EN = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [1:0] RST_SYNC = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} pcil_bus_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] dir;
    } pcil_port_t;

    typedef struct packed {
        logic en;
        logic out;
        logic oe;
    } pcil_alt_t;

    // One-hot select of a pin inside a port
    function automatic logic [7:0] pcil_onehot8(input logic [2:0] idx);
        pcil_onehot8 = 8'h01 << idx;
    endfunction : pcil_onehot8
endpackage : pcil_pkg
`default_nettype wire

//--- rtl/pcil_port.sv
`timescale 1ns/1ps
`default_nettype none
module pcil_port
    import pcil_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Register access
    input wire logic i_we_out,
    input wire logic i_we_dir,
    input wire logic i_we_toggle,
    input wire logic [7:0] i_wdata,
    input wire logic i_bit_we,
    input wire logic i_bit_dir,
    input wire logic [2:0] i_bit_idx,
    input wire logic i_bit_val,
    input wire logic i_pullup_off,
    input wire pcil_alt_t [7:0] i_alt,
    // Pin side
    output pcil_port_t o_cfg,
    output logic [7:0] o_pin_out,
    output logic [7:0] o_pin_oe,
    output logic [7:0] o_pullup
);
    logic [7:0] out_ff;
    logic [7:0] dir_ff;
    logic [7:0] sel;

    assign sel = pcil_onehot8(i_bit_idx);

    // Output data: write, toggle or single-bit op
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_ff <= RST_PORT;
        end else if (i_we_out) begin
            out_ff <= i_wdata;
        end else if (i_we_toggle) begin
            out_ff <= out_ff ^ i_wdata;
        end else if (i_bit_we && !i_bit_dir) begin
            // Only the addressed pin moves
            out_ff <= i_bit_val ? (out_ff | sel)
                                : (out_ff & ~sel);
        end
    end

    // Direction: whole byte or single pin
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_ff <= RST_PORT;
        end else if (i_we_dir) begin
            dir_ff <= i_wdata;
        end else if (i_bit_we && i_bit_dir) begin
            dir_ff <= i_bit_val ? (dir_ff | sel)
                                : (dir_ff & ~sel);
        end
    end

    // Per-pin driver; alternate use of one pin leaves others alone
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            o_pin_out[n] = i_alt[n].en ? i_alt[n].out : out_ff[n];
            o_pin_oe[n] = i_alt[n].en ? i_alt[n].oe : dir_ff[n];
            o_pullup[n] = !i_alt[n].en && !dir_ff[n]
                          && out_ff[n] && !i_pullup_off;
        end
    end

    // Separate flops per field keep one writer for each
    assign o_cfg = '{out: out_ff, dir: dir_ff};
endmodule : pcil_port
`default_nettype wire

//--- rtl/pcil_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcil_top
    import pcil_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Processor side
    input wire logic i_global_irq_enable,
    input wire logic [GROUPS-1:0] i_vector_ack,
    output logic [GROUPS-1:0] o_vector_req,
    // Alternate functions
    input wire pcil_alt_t [PINS-1:0] i_alt,
    // Pins
    input wire logic [PINS-1:0] i_pin,
    output logic [PINS-1:0] o_pin_out,
    output logic [PINS-1:0] o_pin_oe,
    output logic [PINS-1:0] o_pullup_en
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    // Release through two flops, assert at once
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_ff <= RST_SYNC;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    pcil_bus_t bus_ff;
    logic [6:0] idx;
    logic wr_take;
    logic rd_first;
    logic [7:0] wbyte;
    logic [31:0] readdata_ff;
    logic [7:0] rd_byte;

    assign idx = i_avs_address[ADDR_W-1:2];
    assign wbyte = i_avs_writedata[7:0];
    assign rd_first = i_avs_read && bus_ff == BUS_IDLE;
    // Write lands on the edge where waitrequest is seen low
    assign wr_take = i_avs_write && bus_ff == BUS_ANSWER
                     && i_avs_byteenable[0];
    assign o_avs_waitrequest = (i_avs_read || i_avs_write)
                               && bus_ff == BUS_IDLE;
    assign o_avs_readdata = readdata_ff;

    // One wait state per access keeps read data registered
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_ff <= BUS_IDLE;
        end else begin
            case (bus_ff)
                BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_ff <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: begin
                    bus_ff <= BUS_IDLE;
                end
                default: begin
                    bus_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    // Read data captured in the wait cycle, held to the answer edge
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_ff <= 32'h0000_0000;
        end else if (rd_first) begin
            readdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [GROUPS-1:0][7:0] mask_ff;
    logic [7:0] group_en_ff;
    logic [7:0] flags_ff;
    logic pullup_off_ff;
    logic [GROUPS-1:0] mask_we;

    assign mask_we[0] = wr_take && idx == IDX_MASK0;
    assign mask_we[1] = wr_take && idx == IDX_MASK1;
    assign mask_we[2] = wr_take && idx == IDX_MASK2;
    assign mask_we[3] = wr_take && idx == IDX_MASK3;

    // Per-pin masks, zero after reset
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= {GROUPS{RST_MASK}};
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                if (mask_we[g]) begin
                    mask_ff[g] <= wbyte;
                end
            end
        end
    end

    // Group enables and pull-up disable
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            group_en_ff <= RST_GROUP_EN;
            pullup_off_ff <= 1'b0;
        end else begin
            if (wr_take && idx == IDX_GROUP_EN) begin
                group_en_ff <= {4'h0, wbyte[3:0]};
            end
            if (wr_take && idx == IDX_CPU_CTRL) begin
                pullup_off_ff <= wbyte[PULLUP_OFF_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------------
    logic [PINS-1:0] pin_meta_ff;
    logic [PINS-1:0] pin_sync_ff;
    logic [PINS-1:0] pin_prev_ff;
    logic [PINS-1:0] change;
    logic [GROUPS-1:0] grp_hit;

    // Flops clear to zero, so a high pin shows one change after reset;
    // masks are zero then as well, so no flag can set from it
    // Raw pin sampled, so driven outputs count too
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_prev_ff <= '0;
        end else begin
            pin_meta_ff <= i_pin;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // Level against last cycle, masked, ORed per group
    assign change = (pin_sync_ff ^ pin_prev_ff) & mask_ff;
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            grp_hit[g] = |change[g*GROUP_W +: GROUP_W];
        end
    end

    // ------------------------------------------------------------------
    // Group flags
    // ------------------------------------------------------------------
    logic [3:0] flag_clr;
    logic [3:0] nxt_flags;

    // Handler entry or a written one clears
    assign flag_clr = i_vector_ack
                      | ({4{wr_take && idx == IDX_GROUP_FLAGS}}
                         & wbyte[3:0]);
    // A change in the clearing cycle wins; enable not needed
    assign nxt_flags = grp_hit | (flags_ff[3:0] & ~flag_clr);

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= RST_FLAGS;
        end else begin
            flags_ff <= {4'h0, nxt_flags};
        end
    end

    // One vector line per group, gated by both enables
    assign o_vector_req = flags_ff[3:0] & group_en_ff[3:0]
                          & {GROUPS{i_global_irq_enable}};

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    pcil_port_t [GROUPS-1:0] port_cfg;
    logic [GROUPS-1:0] we_in;
    logic [GROUPS-1:0] we_dir;
    logic [GROUPS-1:0] we_out;
    logic [GROUPS-1:0] bit_we;
    logic bitop_take;

    assign bitop_take = wr_take && idx == IDX_BIT_OP;

    // Three addresses per port: input, direction, output
    always_comb begin
        for (int p = 0; p < GROUPS; p++) begin
            we_in[p] = wr_take && idx == 7'(IDX_PORT_BASE
                       + 7'(p) * PORT_STRIDE);
            we_dir[p] = wr_take && idx == 7'(IDX_PORT_BASE
                        + 7'(p) * PORT_STRIDE + 7'h01);
            we_out[p] = wr_take && idx == 7'(IDX_PORT_BASE
                        + 7'(p) * PORT_STRIDE + 7'h02);
            bit_we[p] = bitop_take
                        && wbyte[BITOP_PORT_LSB +: 2] == 2'(p);
        end
    end

    for (genvar p = 0; p < GROUPS; p++) begin : g_port
        pcil_port u_port (
            .i_clock(i_clock),
            .i_rst_n(rst_n),
            .i_we_out(we_out[p]),
            .i_we_dir(we_dir[p]),
            .i_we_toggle(we_in[p]),
            .i_wdata(wbyte),
            .i_bit_we(bit_we[p]),
            .i_bit_dir(wbyte[BITOP_DIR]),
            .i_bit_idx(wbyte[2:0]),
            .i_bit_val(wbyte[BITOP_VAL]),
            .i_pullup_off(pullup_off_ff),
            .i_alt(i_alt[p*8 +: 8]),
            .o_cfg(port_cfg[p]),
            .o_pin_out(o_pin_out[p*8 +: 8]),
            .o_pin_oe(o_pin_oe[p*8 +: 8]),
            .o_pullup(o_pullup_en[p*8 +: 8])
        );
    end

    // ------------------------------------------------------------------
    // Read mux; unmapped reads give zero
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_MASK0: rd_byte = mask_ff[0];
            IDX_MASK1: rd_byte = mask_ff[1];
            IDX_MASK2: rd_byte = mask_ff[2];
            IDX_MASK3: rd_byte = mask_ff[3];
            IDX_GROUP_EN: rd_byte = group_en_ff;
            IDX_GROUP_FLAGS: rd_byte = flags_ff;
            IDX_CPU_CTRL: rd_byte = {3'h0, pullup_off_ff, 4'h0};
            default: rd_byte = 8'h00;
        endcase
        for (int p = 0; p < GROUPS; p++) begin
            if (idx == 7'(IDX_PORT_BASE + 7'(p) * PORT_STRIDE)) begin
                rd_byte = pin_sync_ff[p*8 +: 8];
            end
            if (idx == 7'(IDX_PORT_BASE + 7'(p) * PORT_STRIDE
                          + 7'h01)) begin
                rd_byte = port_cfg[p].dir;
            end
            if (idx == 7'(IDX_PORT_BASE + 7'(p) * PORT_STRIDE
                          + 7'h02)) begin
                rd_byte = port_cfg[p].out;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    grp3_request_a: assert property (
        grp_hit[3] && group_en_ff[3] && i_global_irq_enable
        |=> o_vector_req[3] || !i_global_irq_enable)
        else $error("group 3 change did not request");
    grp2_request_a: assert property (
        grp_hit[2] && group_en_ff[2] && i_global_irq_enable
        |=> o_vector_req[2] || !i_global_irq_enable)
        else $error("group 2 change did not request");
    grp1_request_a: assert property (
        grp_hit[1] && group_en_ff[1] && i_global_irq_enable
        |=> o_vector_req[1] || !i_global_irq_enable)
        else $error("group 1 change did not request");
    grp0_request_a: assert property (
        grp_hit[0] && group_en_ff[0] && i_global_irq_enable
        |=> o_vector_req[0] || !i_global_irq_enable)
        else $error("group 0 change did not request");
    vector_gate_a: assert property (
        |o_vector_req |-> i_global_irq_enable
        && (o_vector_req & ~group_en_ff[3:0]) == 4'h0)
        else $error("vector raised without its enables");
    flag_cause_a: assert property (
        $rose(flags_ff[2]) |-> $past(grp_hit[2]))
        else $error("flag rose without a change");
    flag_ack_a: assert property (
        i_vector_ack[0] && !grp_hit[0] |=> !flags_ff[0])
        else $error("handler did not clear flag");
    flag_zero_write_a: assert property (
        wr_take && idx == IDX_GROUP_FLAGS && !wbyte[0]
        && !i_vector_ack[0] && flags_ff[0] |=> flags_ff[0])
        else $error("zero write cleared a flag");
    mask_block_a: assert property (
        mask_ff[0] == 8'h00 |-> !grp_hit[0])
        else $error("masked pins set a flag");
    toggle_a: assert property (
        we_in[3] && wbyte[0] |=>
        port_cfg[3].out[0] != $past(port_cfg[3].out[0]))
        else $error("toggle write did not invert");
    pullup_off_a: assert property (
        pullup_off_ff |-> o_pullup_en == '0)
        else $error("pull-up on while disabled");
    detect_delay_a: assert property (
        mask_ff[3][0] && $changed(pin_meta_ff[24]) |=> grp_hit[3])
        else $error("change not seen one cycle later");
    bus_answer_a: assert property (
        i_avs_read |-> ##[0:1] !o_avs_waitrequest)
        else $error("read not answered in one wait");
endmodule : pcil_top
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Count every compare; report and count any difference at once
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
    mismatches++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top
    import pcil_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus rows: group, pin, mask, enable, global, flag, request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] g;
        logic [2:0] b;
        logic [7:0] mask;
        logic en;
        logic glb;
        logic flag;
        logic req;
    } pcil_tb_row_t;
    localparam pcil_tb_row_t ROWS [7] = '{
        '{2'h0, 3'h0, 8'h01, 1'h1, 1'h1, 1'h1, 1'h1},
        '{2'h1, 3'h7, 8'h80, 1'h1, 1'h1, 1'h1, 1'h1},
        '{2'h2, 3'h3, 8'h08, 1'h1, 1'h1, 1'h1, 1'h1},
        '{2'h3, 3'h5, 8'h20, 1'h1, 1'h1, 1'h1, 1'h1},
        '{2'h2, 3'h3, 8'hF7, 1'h1, 1'h1, 1'h0, 1'h0},
        '{2'h1, 3'h2, 8'h04, 1'h0, 1'h1, 1'h1, 1'h0},
        '{2'h3, 3'h0, 8'h01, 1'h1, 1'h0, 1'h1, 1'h0}};
    localparam logic [6:0] MIDX [4] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2,
        IDX_MASK3};

    logic i_clock;
    logic rst_n;
    logic [ADDR_W-1:0] avs_addr;
    logic avs_rd;
    logic avs_wr;
    logic [31:0] avs_wdata;
    logic glb;
    logic [GROUPS-1:0] ack;
    logic [PINS-1:0] pin_ext;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [GROUPS-1:0] o_vector_req;
    logic [PINS-1:0] o_pin_out;
    logic [PINS-1:0] o_pin_oe;
    logic [PINS-1:0] o_pullup_en;
    logic [PINS-1:0] pin_lvl;
    logic [7:0] rdata;
    logic [3:0] avs_be;
    pcil_alt_t [PINS-1:0] alt;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    // Driven pins read back their own level, so outputs can trigger
    assign pin_lvl = (o_pin_oe & o_pin_out) | (~o_pin_oe & pin_ext);

    pcil_top dut (
        .i_clock(i_clock), .i_nrst(rst_n),
        .i_avs_address(avs_addr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
        .i_avs_byteenable(avs_be), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_global_irq_enable(glb), .i_vector_ack(ack),
        .o_vector_req(o_vector_req), .i_alt(alt), .i_pin(pin_lvl),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pullup_en(o_pullup_en));

    // ------------------------------------------------------------------
    // Clock, hang guard and closing report
    // ------------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // Whole run is a few hundred cycles; the ceiling leaves ample room
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Bus access: hold until waitrequest is seen low, then release
    // ------------------------------------------------------------------
    task automatic acc(input logic wr, input logic [6:0] idx,
                       input logic [7:0] d);
        @(posedge i_clock);
        avs_addr <= {idx, 2'h0};
        avs_rd <= ~wr;
        avs_wr <= wr;
        avs_wdata <= {24'h000000, d};
        // Waitrequest as each rising edge sees it; the hang guard ends a stall
        do begin
            @(posedge i_clock);
        end while (o_avs_waitrequest !== 1'b0);
        rdata = o_avs_readdata[7:0];
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask : acc

    // Toggle one pin; flag and request are due three edges later
    task automatic flip_pin(input int p);
        @(posedge i_clock);
        pin_ext[p] <= ~pin_ext[p];
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
    endtask : flip_pin

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        pcil_tb_row_t r;
        rst_n = 1'b0;
        avs_addr = '0;
        avs_rd = 1'b0;
        avs_wr = 1'b0;
        avs_wdata = '0;
        glb = 1'b0;
        ack = '0;
        pin_ext = '0;
        avs_be = 4'hF;
        alt = '0;
        repeat (10) @(posedge i_clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        for (int g = 0; g < 4; g++) begin
            acc(1'b0, MIDX[g], 8'h00);
            `CHK(rdata, 8'h00, "mask reset value")
        end
        `CHK(o_vector_req, 4'h0, "request after reset")
        // Table of group, mask, enable and global combinations
        for (int i = 0; i < 7; i++) begin
            r = ROWS[i];
            acc(1'b1, MIDX[r.g], r.mask);
            acc(1'b0, MIDX[r.g], 8'h00);
            `CHK(rdata, r.mask, "mask readback")
            acc(1'b1, IDX_GROUP_EN, 8'(r.en) << r.g);
            glb <= r.glb;
            flip_pin(8 * r.g + r.b);
            `CHK(o_vector_req, 4'(r.req) << r.g, "vector")
            acc(1'b0, IDX_GROUP_FLAGS, 8'h00);
            `CHK(rdata, 8'(r.flag) << r.g, "flag")
            acc(1'b1, IDX_GROUP_FLAGS, 8'h0F);
            acc(1'b1, MIDX[r.g], 8'h00);
        end
        // Writing zero keeps a flag, writing one clears it
        acc(1'b1, IDX_MASK0, 8'h01);
        acc(1'b1, IDX_GROUP_EN, 8'h01);
        glb <= 1'b1;
        flip_pin(0);
        acc(1'b1, IDX_GROUP_FLAGS, 8'h00);
        acc(1'b0, IDX_GROUP_FLAGS, 8'h00);
        `CHK(rdata, 8'h01, "zero write cleared flag")
        acc(1'b1, IDX_GROUP_FLAGS, 8'h01);
        acc(1'b0, IDX_GROUP_FLAGS, 8'h00);
        `CHK(rdata, 8'h00, "one write kept flag")
        // Handler entry clears the flag and drops the request
        flip_pin(0);
        `CHK(o_vector_req, 4'h1, "request before ack")
        @(posedge i_clock);
        ack <= 4'h1;
        @(posedge i_clock);
        ack <= 4'h0;
        @(negedge i_clock);
        `CHK(o_vector_req, 4'h0, "request after ack")
        acc(1'b0, IDX_GROUP_FLAGS, 8'h00);
        `CHK(rdata, 8'h00, "flag after ack")
        // Port 3 registers: output, direction, toggle, bit operations
        acc(1'b1, IDX_PORT_BASE + 7'h0B, 8'h5A);
        acc(1'b1, IDX_PORT_BASE + 7'h0A, 8'h0F);
        acc(1'b1, IDX_PORT_BASE + 7'h09, 8'h0F);
        acc(1'b0, IDX_PORT_BASE + 7'h0B, 8'h00);
        `CHK(rdata, 8'h55, "toggle through pin register")
        acc(1'b0, IDX_PORT_BASE + 7'h0A, 8'h00);
        `CHK(rdata, 8'h0F, "direction readback")
        acc(1'b0, IDX_PORT_BASE + 7'h09, 8'h00);
        `CHK(rdata, (pin_ext[31:24] & 8'hF0) | 8'h05, "pin read")
        acc(1'b1, IDX_BIT_OP, 8'hBF);
        acc(1'b1, IDX_BIT_OP, 8'h18);
        acc(1'b0, IDX_PORT_BASE + 7'h0A, 8'h00);
        `CHK(rdata, 8'h8F, "single-bit direction set")
        acc(1'b0, IDX_PORT_BASE + 7'h0B, 8'h00);
        `CHK(rdata, 8'h54, "single-bit output clear")
        // Output pin toggled by software still raises its group
        acc(1'b1, IDX_MASK3, 8'h01);
        acc(1'b1, IDX_GROUP_FLAGS, 8'h0F);
        acc(1'b1, IDX_PORT_BASE + 7'h09, 8'h01);
        repeat (5) @(posedge i_clock);
        acc(1'b0, IDX_GROUP_FLAGS, 8'h00);
        `CHK(rdata, 8'h08, "output pin change")
        @(negedge i_clock);
        `CHK(o_pin_oe[31:24], 8'h8F, "port 3 drive enables")
        `CHK(o_pin_out[31:24], 8'h55, "port 3 outputs")
        `CHK(o_pullup_en[31:24], 8'h50, "pull-ups on inputs")
        // Alternate use of pin 30 leaves the other port 3 pins alone
        alt[30] <= 3'b101;
        @(negedge i_clock);
        `CHK(o_pin_oe[31:24], 8'hCF, "alternate drive enables")
        `CHK(o_pin_out[31:24], 8'h15, "alternate outputs")
        `CHK(o_pullup_en[31:24], 8'h10, "alternate pull-ups")
        acc(1'b1, IDX_CPU_CTRL, 8'h10);
        @(negedge i_clock);
        `CHK(o_pullup_en, 32'h00000000, "global pull-up disable")
        acc(1'b0, 7'h7F, 8'h00);
        `CHK(rdata, 8'h00, "unmapped read")
        // A write without its low byte lane is ignored
        avs_be <= 4'hE;
        acc(1'b1, IDX_MASK0, 8'hFF);
        avs_be <= 4'hF;
        acc(1'b0, IDX_MASK0, 8'h00);
        `CHK(rdata, 8'h01, "write without byte lane landed")
        // Second reset in mid-run returns masks to zero
        @(posedge i_clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        acc(1'b0, IDX_MASK3, 8'h00);
        `CHK(rdata, 8'h00, "mask after second reset")
        test_done();
    end
endmodule : tb_top
`default_nettype wire
